// >>> rtl/led_ctl.sv
// Chosen here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
module led_ctl #(
  parameter int CLK_HZ = led_ctl_pkg::CLK_HZ
) (
  input  wire logic        CORE_CLK,     // 100 MHz
  input  wire logic        SYS_RST,      // sync, active high
  input  wire logic [3:0]  AWADDR,       // write address
  input  wire logic        AWVALID,      // write address valid
  output logic             AWREADY,      // write address ready
  input  wire logic [31:0] WDATA,        // write data
  input  wire logic [3:0]  WSTRB,        // byte enables
  input  wire logic        WVALID,       // write data valid
  output logic             WREADY,       // write data ready
  output logic [1:0]       BRESP,        // write response
  output logic             BVALID,       // response valid
  input  wire logic        BREADY,       // response ready
  input  wire logic [3:0]  ARADDR,       // read address
  input  wire logic        ARVALID,      // read address valid
  output logic             ARREADY,      // read address ready
  output logic [31:0]      RDATA,        // read data
  output logic [1:0]       RRESP,        // read response
  output logic             RVALID,       // read valid
  input  wire logic        RREADY,       // read ready
  input  wire logic [15:0] LED_IND,      // 4 leds x 4 ports, from phys
  output logic [15:0]      LED_OUT,      // parallel led pins
  output logic             SER_CLK,      // serial led clock
  output logic             SER_DATA,     // serial led data
  output logic             SER_LOAD      // frame latch strobe
);
  led_ctl_pkg::settings_s cfg;
  logic [15:0] set_r;
  logic        pen_r;
  logic        aw_r, w_r;
  logic [3:0]  awa_r;
  logic [15:0] wd_r;
  logic [1:0]  wbe_r;
  assign cfg = led_ctl_pkg::settings_s'(set_r);

  // write: take address and data in either order, answer once both held
  assign AWREADY = !aw_r && !BVALID;
  assign WREADY  = !w_r && !BVALID;
  wire do_wr = aw_r && w_r && !BVALID;
  wire wr_set = awa_r == led_ctl_pkg::ADDR_SETTINGS;
  wire wr_pen = awa_r == led_ctl_pkg::ADDR_PULSE_EN;
  wire [15:0] set_wr = {wbe_r[1] ? wd_r[15:8] : set_r[15:8],
                        wbe_r[0] ? wd_r[7:0] : set_r[7:0]};
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      aw_r <= 1'b0; w_r <= 1'b0; awa_r <= 4'h0; wd_r <= 16'h0000;
      wbe_r <= 2'h0; BVALID <= 1'b0; BRESP <= 2'h0;
      set_r <= led_ctl_pkg::SETTINGS_RST; pen_r <= 1'b0;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_r <= 1'b1; awa_r <= AWADDR;
      end
      if (WVALID && WREADY) begin
        w_r <= 1'b1; wd_r <= WDATA[15:0]; wbe_r <= WSTRB[1:0];
      end
      if (do_wr) begin
        aw_r <= 1'b0; w_r <= 1'b0; BVALID <= 1'b1;
        BRESP <= (wr_set || wr_pen) ? 2'h0 : 2'h2;
        if (wr_set)
          set_r <= set_wr;
        if (wr_pen && wbe_r[0])
          pen_r <= wd_r[0];
      end
      if (BVALID && BREADY)
        BVALID <= 1'b0;
    end
  end

  assign ARREADY = !RVALID;
  wire rd_set = ARADDR == led_ctl_pkg::ADDR_SETTINGS;
  wire rd_pen = ARADDR == led_ctl_pkg::ADDR_PULSE_EN;
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      RVALID <= 1'b0; RDATA <= 32'h0000_0000; RRESP <= 2'h0;
    end else if (ARVALID && ARREADY) begin
      RVALID <= 1'b1;
      RDATA  <= rd_set ? {16'h0000, set_r} :
                rd_pen ? {31'h0, pen_r} : 32'h0000_0000;
      RRESP  <= (rd_set || rd_pen) ? 2'h0 : 2'h2;
    end else if (RVALID && RREADY)
      RVALID <= 1'b0;
  end

  // pulse pwm: 200 slots, led on for duty+1 slots
  localparam int SLOT = CLK_HZ / (led_ctl_pkg::PWM_HZ * 200);
  logic [15:0] slot_cnt_r;
  logic [7:0]  pwm_cnt_r;
  wire slot_tick = slot_cnt_r == 16'(SLOT - 1);
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      slot_cnt_r <= 16'h0000; pwm_cnt_r <= 8'h00;
    end else begin
      slot_cnt_r <= slot_tick ? 16'h0000 : slot_cnt_r + 16'h0001;
      if (slot_tick)
        pwm_cnt_r <= (pwm_cnt_r == led_ctl_pkg::PWM_PERIOD - 8'h01) ?
                     8'h00 : pwm_cnt_r + 8'h01;
    end
  end
  // values past 198 are invalid; they saturate to always-on
  wire pwm_on = pwm_cnt_r <= cfg.duty;
  wire pulse_gate = pen_r ? pwm_on : 1'b1;

  // port swap exchanges port 0<->1 and 2<->3
  wire [15:0] ind_sw = cfg.swap ? {LED_IND[11:8], LED_IND[15:12],
                                   LED_IND[3:0], LED_IND[7:4]}
                                : LED_IND;
  wire [15:0] ind = ind_sw & {16{pulse_gate}};

  // frame rate: frame period = 16 bit slots * 2 edges each
  logic [31:0] fdiv;
  always_comb begin
    unique case (cfg.rate)
      3'h0: fdiv = 32'(CLK_HZ / (2500 * 32));
      3'h1: fdiv = 32'(CLK_HZ / (1000 * 32));
      3'h2: fdiv = 32'(CLK_HZ / (500 * 32));
      3'h3: fdiv = 32'(CLK_HZ / (250 * 32));
      3'h4: fdiv = 32'(CLK_HZ / (200 * 32));
      3'h5: fdiv = 32'(CLK_HZ / (125 * 32));
      3'h6: fdiv = 32'(CLK_HZ / (40 * 32));
      3'h7: fdiv = 32'(CLK_HZ / (led_ctl_pkg::BASIC_HZ * 32));
    endcase
  end
  logic [31:0] div_r;
  logic [4:0]  half_r;
  logic [15:0] shf_r;
  logic [4:0]  nbits_r;
  wire half_tick = div_r >= fdiv - 32'h1;
  // selection keeps only the lowest n leds of every phy
  logic [15:0] sel_ind;
  logic [4:0]  nbits;
  always_comb begin
    unique case (cfg.sel)
      2'h0: begin sel_ind = ind; nbits = 5'h10; end
      2'h1: begin
        sel_ind = {4'h0, ind[14:12], ind[10:8], ind[6:4], ind[2:0]};
        nbits = 5'h0C;
      end
      2'h2: begin
        sel_ind = {8'h00, ind[13:12], ind[9:8], ind[5:4], ind[1:0]};
        nbits = 5'h08;
      end
      2'h3: begin
        sel_ind = {12'h000, ind[12], ind[8], ind[4], ind[0]};
        nbits = 5'h04;
      end
    endcase
  end
  // basic stream: all 16 indications, no pulsing, no selection
  wire basic = cfg.rate == led_ctl_pkg::RATE_BASIC;
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      div_r <= 32'h0; half_r <= 5'h00; shf_r <= 16'h0000;
      nbits_r <= 5'h10; SER_CLK <= 1'b0; SER_DATA <= 1'b0;
      SER_LOAD <= 1'b0;
    end else begin
      SER_LOAD <= 1'b0;
      div_r <= half_tick ? 32'h0 : div_r + 32'h1;
      if (half_tick) begin
        half_r <= half_r + 5'h01;
        SER_CLK <= half_r[0];
        if (half_r == 5'h00) begin
          shf_r   <= basic ? LED_IND : sel_ind;
          nbits_r <= basic ? 5'h10 : nbits;
        end else if (half_r[0]) begin
          SER_DATA <= shf_r[0];
          shf_r <= {1'b0, shf_r[15:1]};
        end
        if (half_r == 5'h1F)
          SER_LOAD <= 1'b1;
      end
    end
  end

  // pins with enable take the serial signals, others stay parallel
  wire [3:0] ser_pins = {SER_LOAD, SER_DATA, SER_CLK, 1'b0};
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST)
      LED_OUT <= 16'h0000;
    else begin
      LED_OUT[15:8] <= ind[15:8];
      LED_OUT[7:4]  <= cfg.p1_en ? ser_pins : ind[7:4];
      LED_OUT[3:0]  <= cfg.p0_en ? ser_pins : ind[3:0];
    end
  end

  AST_P1_SERIAL: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    cfg.p1_en |=> LED_OUT[5] == $past(SER_CLK))
    else $error("port 1 pins not serial");
  AST_P0_NORMAL: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    !cfg.p0_en |=> LED_OUT[3:0] == $past(ind[3:0]))
    else $error("port 0 pins not normal");
  AST_DUTY_OFF: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    (pen_r && pwm_cnt_r > cfg.duty) |-> !pulse_gate)
    else $error("led on past duty");
  AST_DUTY_MIN: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    (pen_r && pwm_cnt_r == 8'h00) |-> pulse_gate)
    else $error("no minimum on slot");
  AST_STEADY: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    !pen_r |-> ind == ind_sw)
    else $error("pulsing while disabled");
  AST_SWAP: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    cfg.swap |-> ind_sw[3:0] == LED_IND[7:4])
    else $error("swap not applied");
  AST_SEL_ONE: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    cfg.sel == 2'h3 |-> sel_ind[15:4] == 12'h000)
    else $error("extra leds on stream");
  AST_RATE: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    cfg.rate == 3'h0 |-> fdiv == 32'(CLK_HZ / 80000))
    else $error("rate divider wrong");
  AST_PWM_WRAP: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    pwm_cnt_r < led_ctl_pkg::PWM_PERIOD)
    else $error("pwm counter out of range");
  // a loaded frame never carries leds beyond the selected count
  AST_SEL_WIDTH: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    (half_r == 5'h01) |-> (shf_r >> nbits_r) == 16'h0000)
    else $error("frame wider than selection");
  AST_LOAD_ONE: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    SER_LOAD |=> !SER_LOAD)
    else $error("frame latch longer than one cycle");
  // address and data both held, settings addressed: the word must land
  sequence s_set_write;
    do_wr && wr_set;
  endsequence
  AST_SET_WRITE: assert property (
    @(posedge CORE_CLK) disable iff (SYS_RST)
    s_set_write |=> set_r == $past(set_wr))
    else $error("settings write lost");
endmodule
`default_nettype wire

// >>> common/led_ctl_pkg.sv
`default_nettype none
package led_ctl_pkg;
  localparam logic [3:0]  ADDR_SETTINGS  = 4'h0;
  localparam logic [3:0]  ADDR_PULSE_EN  = 4'h4;
  localparam logic [15:0] SETTINGS_RST   = 16'h0000;
  localparam int          DUTY_LSB       = 8;
  localparam logic [7:0]  DUTY_MAX       = 8'hC6;
  localparam logic [7:0]  PWM_PERIOD     = 8'hC8;
  localparam int          P1_EN_BIT      = 7;
  localparam int          P0_EN_BIT      = 6;
  localparam int          RATE_LSB       = 3;
  localparam int          SEL_LSB        = 1;
  localparam int          SWAP_BIT       = 0;
  localparam logic [2:0]  RATE_BASIC     = 3'h7;
  localparam int          CLK_HZ         = 100_000_000;
  localparam int          PWM_HZ         = 200;
  // pwm slot: 200 slots per pulse period of 1/PWM_HZ
  localparam int          SLOT_CYC       = CLK_HZ / (PWM_HZ * 200);
  localparam int          FRAME_BITS     = 16;
  localparam int          BASIC_HZ       = 2500;
  typedef struct packed {
    logic [7:0] duty;
    logic       p1_en;
    logic       p0_en;
    logic [2:0] rate;
    logic [1:0] sel;
    logic       swap;
  } settings_s;
endpackage
`default_nettype wire

// >>> tb/led_sink.sv
`timescale 1ns/1ps
`default_nettype none
module led_sink (
  input  wire logic        clk,   // core clock
  input  wire logic        sclk,  // serial clock
  input  wire logic        sdat,  // serial data
  input  wire logic        sload, // frame latch
  output logic [15:0]      word,  // last latched frame
  output logic             got    // frame strobe
);
  logic        sclk_r;
  logic [15:0] sh_r;
  logic [15:0] sh_nxt;
  // a shift may coincide with the latch, so latch the shifted value
  assign sh_nxt = (sclk && !sclk_r) ? {sdat, sh_r[15:1]} : sh_r;
  always_ff @(posedge clk) begin
    sclk_r <= sclk;
    got    <= sload;
    sh_r   <= sh_nxt; // first bit ends in bit 0
    if (sload) word <= sh_nxt;
  end
endmodule
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int HZ = 160000; // keeps every divider an integer
  logic        clk = 0, rst = 1, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic [3:0]  awa = 0, ara = 0, s3;
  logic [31:0] wd = 0, rdat;
  logic        awr, wrdy, bv, arr, rv, sck, sdt, sld, fgot;
  logic [1:0]  bresp, rresp;
  logic [15:0] ind = 0, lo, fw, v;
  logic [33:0] q[$];
  int          n_errors = 0, n_checks = 0, seed = 59526, c, p, n, k, d;
  int          rt[8] = '{2500, 1000, 500, 250, 200, 125, 40, 2500};
  led_ctl #(.CLK_HZ(HZ)) led_ctl_i (.CORE_CLK(clk), .SYS_RST(rst),
    .AWADDR(awa), .AWVALID(awv), .AWREADY(awr), .WDATA(wd),
    .WSTRB(4'hF), .WVALID(wv), .WREADY(wrdy), .BRESP(bresp), .BVALID(bv),
    .BREADY(br), .ARADDR(ara), .ARVALID(arv), .ARREADY(arr),
    .RDATA(rdat), .RRESP(rresp), .RVALID(rv), .RREADY(rr),
    .LED_IND(ind), .LED_OUT(lo), .SER_CLK(sck), .SER_DATA(sdt),
    .SER_LOAD(sld));
  led_sink led_sink_i (.clk(clk), .sclk(sck), .sdat(sdt), .sload(sld),
    .word(fw), .got(fgot));
  initial forever #5 clk = ~clk;
  task chk(input logic [33:0] g, input logic [33:0] e);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task finish_test;
    if (n_errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // lowest leds of every phy first, packed from bit 0 upward
  function automatic logic [15:0] pick(input logic [15:0] x, input int s);
    int j;
    pick = 16'h0000;
    j = 0;
    for (int ph = 0; ph < 4; ph++) begin
      for (int l = 0; l < 4 - s; l++) begin
        pick[j] = x[4 * ph + l];
        j++;
      end
    end
  endfunction
  task wr(input logic [3:0] a, input logic [31:0] dat);
    awa <= a; wd <= dat; awv <= 1; wv <= 1; br <= 1;
    do begin
      @(posedge clk);
      if (awr) awv <= 0;
      if (wrdy) wv <= 0;
    end while (!bv);
    br <= 0;
    // one edge apart, so a following call never reassigns in this step
    @(posedge clk);
  endtask
  task rd(input logic [3:0] a, input logic [33:0] e);
    ara <= a; arv <= 1; rr <= 1;
    q.push_back(e);
    do begin
      @(posedge clk);
      if (arr) arv <= 0;
    end while (!rv);
    rr <= 0;
    @(posedge clk);
  endtask
  // read results are matched in issue order
  always @(posedge clk)
    if (rv && rr) chk({rresp, rdat}, q.pop_front());
  task per(output int m);
    k = 0;
    m = 0;
    while (k < 3 && m < 20000) begin
      @(posedge clk);
      m++;
      if (sld) begin
        k++;
        if (k < 3) m = 0;
      end
    end
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    rd(4'h0, 34'h0);
    v = 16'($random(seed));
    v[15:8] = 8'({$random(seed)} % 199);
    wr(4'h0, {16'h0, v});
    rd(4'h0, {18'h0, v});
    rd(4'h8, {2'h2, 32'h0});
    ind <= 16'($random(seed));
    for (p = 0; p < 2; p++) begin
      wr(4'h0, 32'h0500 | 32'(p));
      repeat (3) @(posedge clk);
      v = p ? {ind[11:8], ind[15:12], ind[3:0], ind[7:4]} : ind;
      chk(34'(lo), 34'(v));
    end
    for (p = 0; p < 2; p++) begin
      wr(4'h0, 32'h40 << p);
      repeat (2) @(posedge clk);
      #1;
      repeat (100) begin
        s3 = {sld, sdt, sck, 1'b0};
        @(posedge clk);
        #1;
        chk(34'(lo[4*p+:4]), 34'(s3));
        chk(34'(lo[4*(1-p)+:4]), 34'(ind[4*(1-p)+:4]));
      end
      @(posedge clk);
    end
    // every selection code rides along with one of the rates
    for (c = 0; c < 8; c++) begin
      wr(4'h0, 32'(c << 3) | 32'((c % 4) << 1));
      per(n);
      chk(34'(n), 34'(HZ / rt[c]));
      for (k = 0; k < 5000 && !fgot; k++) @(posedge clk);
      v = (c == 7) ? ind : pick(ind, c % 4);
      chk(34'(fw), 34'(v));
    end
    wr(4'h4, 32'h1);
    ind <= 16'hFFFF;
    for (c = 0; c < 3; c++) begin
      d = (c == 0) ? 0 : (c == 1) ? {$random(seed)} % 199 : 198;
      wr(4'h0, 32'(d << 8));
      repeat (4) @(posedge clk);
      n = 0;
      // one whole pulse period of 200 slots, 4 cycles each
      repeat (800) begin
        @(posedge clk);
        n += lo[0];
      end
      chk(34'(n), 34'((d + 1) * 4));
    end
    finish_test;
  end
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    finish_test;
  end
endmodule
`default_nettype wire
